/* File: pkg/cps_consts.vh */
// Behaviour
// - reset loads factory trim into trim register
// - trim bit 7 selects low/high range
// - low seven bits tune within range
// - enable sets only on 0x80 exact write
// - enable clears after four cycles or select write
// - rewrite during window neither restarts nor clears
// - divide by two to the select value
// - reset select 0000, or 0011 with fuse
// - select accepts only values 0 to 8, regardless of fuse
// - divided clock feeds cpu and peripherals
// - sleep only when sleep enable set
// - mode select bits pick sleep mode
// - wake on interrupt, hold cpu four extra
// - wake leaves register file and sram intact
// - reset during sleep restarts at reset vector
// - per-mode clock domain gating
// - async domain during sleep only with async timer running, always on while awake
// - per-mode wake source masks
// - brownout disable only in deep modes
// - sleep mode select encoding
// - glitch-free divider change timing
`ifndef CPS_CONSTS_VH
`define CPS_CONSTS_VH
`define CPS_OFF_TRIM 12'h000
`define CPS_OFF_DIV 12'h004
`define CPS_OFF_SLEEP 12'h008
`define CPS_OFF_STATUS 12'h00C
`define CPS_DIV_CE_BIT 7
`define CPS_DIV_CE_PATTERN 8'h80
`define CPS_DIV_CE_CYCLES 3'h4
`define CPS_DIV_MAX 4'h8
`define CPS_DIV_RST_FUSE 4'h3
`define CPS_DIV_RST_PLAIN 4'h0
`define CPS_WAKE_HOLD 3'h4
`define CPS_SM_IDLE 3'h0
`define CPS_SM_ADCNR 3'h1
`define CPS_SM_PDOWN 3'h2
`define CPS_SM_PSAVE 3'h3
`define CPS_SM_STBY 3'h6
`define CPS_SM_XSTBY 3'h7
`endif

/* File: src/cps_clock_sleep.v */
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "cps_consts.vh"
module cps_clock_sleep #(
  parameter [7:0] FACTORY_TRIM = 8'h80,
  parameter [7:0] STARTUP_CYCLES = 8'h06
) (
  input wire sys_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire initial_div8_fuse,
  input wire sleep_instr,
  input wire async_timer_running,
  input wire bod_disable_req,
  input wire wake_ext_int,
  input wire wake_twi_match,
  input wire wake_wdt,
  input wire wake_async_timer,
  input wire wake_spm_ee,
  input wire wake_adc,
  input wire wake_other_io,
  output reg [7:0] rc_oscillator_trim,
  output reg clk_sys_en,
  output reg clk_cpu_en,
  output reg clk_flash_en,
  output reg clk_io_en,
  output reg clk_adc_en,
  output reg clk_asy_en,
  output reg main_osc_en,
  output reg timer_osc_en,
  output reg brownout_off,
  output reg cpu_hold,
  output reg cpu_reset_vector
);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  reg [9:0] sync1_q;
  reg [9:0] sync2_q;
  // wake inputs come from other domains; reset level only, no strap
  always @(posedge sys_clk) begin
    if (!rstn) begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end else begin
      sync1_q <= {initial_div8_fuse, async_timer_running, wake_other_io, wake_adc,
                  wake_spm_ee, wake_async_timer, wake_wdt, wake_twi_match, wake_ext_int, bod_disable_req};
      sync2_q <= sync1_q;
    end
  end
  wire fuse_s = sync2_q[9];
  wire async_run_s = sync2_q[8];

  // ==========================================================
  // apb register access
  // ==========================================================
  wire acc = psel & penable & ~pready;
  wire wr = acc & pwrite;
  wire wr_trim = wr & (paddr == `CPS_OFF_TRIM);
  wire wr_div = wr & (paddr == `CPS_OFF_DIV);
  wire wr_sleep = wr & (paddr == `CPS_OFF_SLEEP);
  wire mapped = (paddr == `CPS_OFF_TRIM) | (paddr == `CPS_OFF_DIV) |
                (paddr == `CPS_OFF_SLEEP) | (paddr == `CPS_OFF_STATUS);

  reg div_ce_q;
  reg [2:0] ce_cnt_q;
  reg [3:0] div_sel_q;
  reg fuse_seen_q;
  reg [1:0] fuse_dly_q;
  reg sleep_en_q;
  reg [2:0] sleep_mode_q;
  reg bods_q;
  reg asleep_q;
  reg [7:0] wake_cnt_q;
  reg waking_q;

  // one wait state keeps the answer one cycle after access start
  always @(posedge sys_clk) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~mapped;
      if (acc & ~pwrite) begin
        case (paddr)
          `CPS_OFF_TRIM: prdata <= {24'h000000, rc_oscillator_trim};
          `CPS_OFF_DIV: prdata <= {24'h000000, div_ce_q, 3'h0, div_sel_q};
          `CPS_OFF_SLEEP: prdata <= {24'h000000, 3'h0, bods_q, sleep_mode_q, sleep_en_q};
          `CPS_OFF_STATUS: prdata <= {24'h000000, 2'h0, waking_q, asleep_q, 4'h0};
          default: prdata <= 32'h00000000;
        endcase
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ==========================================================
  // trim register
  // ==========================================================
  // bit 7 range, bits 6:0 fine tune go straight to the analog oscillator
  always @(posedge sys_clk) begin
    if (!rstn) begin
      rc_oscillator_trim <= FACTORY_TRIM;
    end else if (wr_trim) begin
      rc_oscillator_trim <= pwdata[7:0];
    end
  end

  // ==========================================================
  // divide control with protected change
  // ==========================================================
  function valid_code;
    input [3:0] c;
    begin
      valid_code = (c <= `CPS_DIV_MAX);
    end
  endfunction

  wire ce_write = wr_div & (pwdata[7:0] == `CPS_DIV_CE_PATTERN);
  wire sel_write = wr_div & div_ce_q & ~pwdata[`CPS_DIV_CE_BIT];

  // fuse is sampled through the synchroniser after release
  always @(posedge sys_clk) begin
    if (!rstn) begin
      div_ce_q <= 1'b0;
      ce_cnt_q <= 3'h0;
      div_sel_q <= `CPS_DIV_RST_PLAIN;
      fuse_seen_q <= 1'b0;
      fuse_dly_q <= 2'h0;
    end else begin
      fuse_dly_q <= {fuse_dly_q[0], 1'b1};
      // second stage holds the pin only two edges after release
      if (!fuse_seen_q && fuse_dly_q[1]) begin
        fuse_seen_q <= 1'b1;
        div_sel_q <= fuse_s ? `CPS_DIV_RST_FUSE : `CPS_DIV_RST_PLAIN;
      end
      if (sel_write) begin
        div_ce_q <= 1'b0;
        ce_cnt_q <= 3'h0;
        if (valid_code(pwdata[3:0]))
          div_sel_q <= pwdata[3:0];
      end else if (div_ce_q) begin
        // a rewrite does not touch the counter
        if (ce_cnt_q == `CPS_DIV_CE_CYCLES - 3'h1) begin
          div_ce_q <= 1'b0;
          ce_cnt_q <= 3'h0;
        end else begin
          ce_cnt_q <= ce_cnt_q + 3'h1;
        end
      end else if (ce_write) begin
        div_ce_q <= 1'b1;
        ce_cnt_q <= 3'h0;
      end
    end
  end

  // ==========================================================
  // glitch-free divider
  // ==========================================================
  reg [7:0] div_cnt_q;
  reg [3:0] div_act_q;
  reg div_pend_q;
  function [7:0] div_last;
    input [3:0] c;
    begin
      div_last = (8'h01 << c) - 8'h01;
    end
  endfunction
  // new factor latched only at a period boundary, so no short pulse
  always @(posedge sys_clk) begin
    if (!rstn) begin
      div_cnt_q <= 8'h00;
      div_act_q <= `CPS_DIV_RST_PLAIN;
      div_pend_q <= 1'b0;
      clk_sys_en <= 1'b0;
    end else begin
      if (div_act_q != div_sel_q)
        div_pend_q <= 1'b1;
      if (div_cnt_q >= div_last(div_act_q)) begin
        div_cnt_q <= 8'h00;
        clk_sys_en <= 1'b1;
        if (div_pend_q || div_act_q != div_sel_q) begin
          div_act_q <= div_sel_q;
          div_pend_q <= 1'b0;
        end
      end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
        clk_sys_en <= 1'b0;
      end
    end
  end

  // ==========================================================
  // sleep control register
  // ==========================================================
  always @(posedge sys_clk) begin
    if (!rstn) begin
      sleep_en_q <= 1'b0;
      sleep_mode_q <= `CPS_SM_IDLE;
      bods_q <= 1'b0;
    end else if (wr_sleep) begin
      sleep_en_q <= pwdata[0];
      sleep_mode_q <= pwdata[3:1];
      bods_q <= pwdata[4];
    end
  end

  // ==========================================================
  // wake source decode
  // ==========================================================
  function wake_ok;
    input [2:0] m;
    input [6:0] w;
    reg deep;
    begin
      deep = ~((m == `CPS_SM_IDLE) | (m == `CPS_SM_ADCNR) | (m == `CPS_SM_PSAVE) | (m == `CPS_SM_XSTBY));
      wake_ok = w[0] | w[1] | w[2] |
                (w[3] & ~deep) |
                ((w[4] | w[5]) & ((m == `CPS_SM_IDLE) | (m == `CPS_SM_ADCNR))) |
                (w[6] & (m == `CPS_SM_IDLE));
    end
  endfunction
  wire wake_now = wake_ok(sleep_mode_q, sync2_q[7:1]);
  // unused codes behave as power-down, so they allow it too
  wire bod_mode = (sleep_mode_q != `CPS_SM_IDLE) &
                  (sleep_mode_q != `CPS_SM_ADCNR);

  // ==========================================================
  // sleep state machine
  // ==========================================================
  // reset leaves via rstn: cpu restarts at vector, not after sleep
  always @(posedge sys_clk) begin
    if (!rstn) begin
      asleep_q <= 1'b0;
      waking_q <= 1'b0;
      wake_cnt_q <= 8'h00;
      cpu_reset_vector <= 1'b1;
    end else begin
      cpu_reset_vector <= 1'b0;
      if (!asleep_q && !waking_q) begin
        if (sleep_instr && sleep_en_q)
          asleep_q <= 1'b1;
      end else if (asleep_q) begin
        if (wake_now) begin
          asleep_q <= 1'b0;
          waking_q <= 1'b1;
          wake_cnt_q <= STARTUP_CYCLES + {5'h00, `CPS_WAKE_HOLD};
        end
      end else if (wake_cnt_q == 8'h01) begin
        waking_q <= 1'b0;
        wake_cnt_q <= 8'h00;
      end else begin
        wake_cnt_q <= wake_cnt_q - 8'h01;
      end
    end
  end

  // ==========================================================
  // clock domain gating
  // ==========================================================
  // memory never reset by this block, so contents survive sleep
  always @(posedge sys_clk) begin
    if (!rstn) begin
      clk_cpu_en <= 1'b1;
      clk_flash_en <= 1'b1;
      clk_io_en <= 1'b1;
      clk_adc_en <= 1'b1;
      clk_asy_en <= 1'b1;
      main_osc_en <= 1'b1;
      timer_osc_en <= 1'b0;
      brownout_off <= 1'b0;
      cpu_hold <= 1'b0;
    end else begin
      cpu_hold <= asleep_q | waking_q;
      brownout_off <= asleep_q & bods_q & bod_mode;
      if (!asleep_q) begin
        clk_cpu_en <= ~waking_q;
        clk_flash_en <= ~waking_q;
        clk_io_en <= 1'b1;
        clk_adc_en <= 1'b1;
        clk_asy_en <= 1'b1;
        main_osc_en <= 1'b1;
        timer_osc_en <= async_run_s;
      end else begin
        clk_cpu_en <= 1'b0;
        clk_flash_en <= 1'b0;
        case (sleep_mode_q)
          `CPS_SM_IDLE: begin
            clk_io_en <= 1'b1;
            clk_adc_en <= 1'b1;
            clk_asy_en <= async_run_s;
            main_osc_en <= 1'b1;
            timer_osc_en <= async_run_s;
          end
          `CPS_SM_ADCNR: begin
            clk_io_en <= 1'b0;
            clk_adc_en <= 1'b1;
            clk_asy_en <= async_run_s;
            main_osc_en <= 1'b1;
            timer_osc_en <= async_run_s;
          end
          `CPS_SM_PSAVE: begin
            clk_io_en <= 1'b0;
            clk_adc_en <= 1'b0;
            clk_asy_en <= async_run_s;
            main_osc_en <= 1'b0;
            timer_osc_en <= async_run_s;
          end
          `CPS_SM_STBY: begin
            clk_io_en <= 1'b0;
            clk_adc_en <= 1'b0;
            clk_asy_en <= 1'b0;
            main_osc_en <= 1'b1;
            timer_osc_en <= 1'b0;
          end
          `CPS_SM_XSTBY: begin
            clk_io_en <= 1'b0;
            clk_adc_en <= 1'b0;
            clk_asy_en <= async_run_s;
            main_osc_en <= 1'b1;
            timer_osc_en <= async_run_s;
          end
          default: begin
            // power-down and unused codes stop everything
            clk_io_en <= 1'b0;
            clk_adc_en <= 1'b0;
            clk_asy_en <= 1'b0;
            main_osc_en <= 1'b0;
            timer_osc_en <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // cps_clock_sleep

/* File: testbench/cps_checker.sv */
`timescale 1ns/100ps
// ====
// port checker
module cps_checker #(
  parameter [7:0] FACTORY_TRIM = 8'h80,
  parameter [7:0] STARTUP_CYCLES = 8'h06
) (
  input wire sys_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] rc_oscillator_trim,
  input wire sleep_instr,
  input wire clk_cpu_en,
  input wire clk_flash_en,
  input wire clk_io_en,
  input wire clk_adc_en,
  input wire brownout_off,
  input wire cpu_hold,
  input wire cpu_reset_vector
);
  reg [7:0] hold_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_fall_asleep;
    !cpu_hold ##1 cpu_hold;
  endsequence
  // cycles held, saturating so a long sleep never wraps
  always @(posedge sys_clk) begin
    if (!rstn || !cpu_hold)
      hold_q <= 8'h00;
    else if (hold_q != 8'hFF)
      hold_q <= hold_q + 8'h01;
  end
  a_pready_wait: assert property (s_access |=> pready) else $error("no answer");
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_unmapped_err: assert property (pready && paddr > 12'h00C |-> pslverr) else $error("no slave error");
  a_trim_reset: assert property ($rose(rstn) |-> rc_oscillator_trim == FACTORY_TRIM)
    else $error("trim reset value");
  a_trim_write: assert property (s_access and (pwrite && paddr == 12'h000) |=> rc_oscillator_trim == pwdata[7:0])
    else $error("trim write lost");
  a_sleep_cause: assert property (s_fall_asleep |-> $past(sleep_instr) || $past(sleep_instr, 2))
    else $error("sleep without instruction");
  a_cpu_flash_pair: assert property (clk_cpu_en == clk_flash_en) else $error("cpu flash split");
  a_io_needs_adc: assert property (clk_io_en |-> clk_adc_en) else $error("io clock without adc clock");
  a_bod_deep_only: assert property (brownout_off |-> cpu_hold && !clk_io_en)
    else $error("brownout off outside deep sleep");
  a_wake_hold: assert property ($fell(cpu_hold) |-> hold_q >= STARTUP_CYCLES + 8'h04)
    else $error("wake hold short");
  a_reset_restart: assert property ($rose(rstn) |-> cpu_reset_vector && !cpu_hold)
    else $error("reset did not restart");
endmodule // cps_checker

bind cps_clock_sleep cps_checker #(.FACTORY_TRIM(FACTORY_TRIM), .STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (
  .sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .rc_oscillator_trim,
  .sleep_instr, .clk_cpu_en, .clk_flash_en, .clk_io_en, .clk_adc_en, .brownout_off, .cpu_hold, .cpu_reset_vector);

/* File: testbench/cps_cpu_model.sv */
`timescale 1ns/100ps
// ====
// cpu core stand-in
module cps_cpu_model (
  input wire sys_clk,
  input wire sleep_req,
  output reg sleep_instr
);
  // sleep instruction is the request delayed one cycle, as long as the request
  always @(posedge sys_clk) begin
    sleep_instr <= sleep_req;
  end
endmodule // cps_cpu_model

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`include "cps_consts.vh"
// ====
// bench top
module tb_top;
  reg sys_clk, rstn, psel, penable, pwrite, initial_div8_fuse, sleep_req, er;
  reg wake_ext_int, wake_twi_match, wake_wdt, wake_other_io, wake_adc;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, sleep_instr, clk_sys_en, clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_asy_en;
  wire main_osc_en, timer_osc_en, brownout_off, cpu_hold, cpu_reset_vector;
  wire [7:0] rc_oscillator_trim;
  integer n_fail, checks, i, k;
  cps_clock_sleep u_dut (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .initial_div8_fuse, .sleep_instr, .async_timer_running(1'b0), .bod_disable_req(1'b0), .wake_ext_int,
    .wake_twi_match, .wake_wdt, .wake_async_timer(1'b0), .wake_spm_ee(1'b0), .wake_adc, .wake_other_io,
    .rc_oscillator_trim, .clk_sys_en, .clk_cpu_en, .clk_flash_en, .clk_io_en, .clk_adc_en, .clk_asy_en,
    .main_osc_en, .timer_osc_en, .brownout_off, .cpu_hold, .cpu_reset_vector);
  cps_cpu_model u_cpu (.sys_clk, .sleep_req, .sleep_instr);
  // clocks {cpu,flash,io,adc,asy,main,bod}; async timer is idle here
  function [6:0] gate_of(input [2:0] m);
    case (m)
      3'h0: gate_of = 7'h1A;
      3'h1: gate_of = 7'h0A;
      3'h6, 3'h7: gate_of = 7'h03;
      default: gate_of = 7'h01;
    endcase
  endfunction
  task stop_test;
    begin
      $display("mismatches %0d checks %0d", n_fail, checks);
      if (n_fail == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // one apb transfer; the watchdog bounds the wait for pready
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdc(input [11:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
    end
  endtask
  task do_reset(input f);
    begin
      rstn <= 1'b0;
      initial_div8_fuse <= f;
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  task sleep_now;
    begin
      @(posedge sys_clk);
      sleep_req <= 1'b1;
      @(posedge sys_clk);
      sleep_req <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #(50 * 8000);
    n_fail = n_fail + 1;
    $display("BAD %0t timeout", $time);
    stop_test;
  end
  initial begin
    n_fail = 0;
    checks = 0;
    {psel, penable, pwrite, sleep_req, wake_ext_int, wake_twi_match, wake_wdt, wake_other_io, wake_adc} = 9'h000;
    paddr = 12'h000;
    pwdata = 32'h0;
    do_reset(1'b0);
    rdc(`CPS_OFF_TRIM, 32'h80);
    rdc(`CPS_OFF_DIV, 32'h0);
    apb(1'b1, `CPS_OFF_TRIM, 32'h7F);
    rdc(`CPS_OFF_TRIM, 32'h7F);
    chk(rc_oscillator_trim, 32'h7F);
    rdc(12'h010, 32'h0);
    chk(er, 1'b1);
    // enable must be the exact pattern, then a select write inside the window
    apb(1'b1, `CPS_OFF_DIV, 32'h81);
    apb(1'b1, `CPS_OFF_DIV, 32'h5);
    rdc(`CPS_OFF_DIV, 32'h0);
    apb(1'b1, `CPS_OFF_DIV, 32'h80);
    apb(1'b1, `CPS_OFF_DIV, 32'h5);
    rdc(`CPS_OFF_DIV, 32'h5);
    apb(1'b1, `CPS_OFF_DIV, 32'h80);
    apb(1'b1, `CPS_OFF_DIV, 32'h9);
    rdc(`CPS_OFF_DIV, 32'h5);
    apb(1'b1, `CPS_OFF_DIV, 32'h80);
    repeat (6) @(posedge sys_clk);
    apb(1'b1, `CPS_OFF_DIV, 32'h2);
    rdc(`CPS_OFF_DIV, 32'h5);
    apb(1'b1, `CPS_OFF_DIV, 32'h80);
    apb(1'b1, `CPS_OFF_DIV, 32'h80);
    apb(1'b1, `CPS_OFF_DIV, 32'h2);
    rdc(`CPS_OFF_DIV, 32'h5);
    apb(1'b1, `CPS_OFF_DIV, 32'h80);
    apb(1'b1, `CPS_OFF_DIV, 32'h2);
    rdc(`CPS_OFF_DIV, 32'h2);
    // old factor 32 may run one full period before the switch
    repeat (40) @(posedge sys_clk);
    k = 0;
    repeat (64) begin
      @(posedge sys_clk);
      if (clk_sys_en === 1'b1)
        k = k + 1;
    end
    chk(k, 16);
    apb(1'b1, `CPS_OFF_SLEEP, 32'h0);
    sleep_now;
    chk(cpu_hold, 1'b0);
    // every mode code: gating, a partial wake source, then a full one
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b1, `CPS_OFF_SLEEP, {27'h0, 1'b1, i[2:0], 1'b1});
      sleep_now;
      chk({clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_asy_en, main_osc_en, brownout_off}, gate_of(i[2:0]));
      {wake_adc, wake_other_io} <= 2'h3;
      repeat (30) @(posedge sys_clk);
      chk(cpu_hold, i > 1);
      {wake_wdt, wake_twi_match, wake_ext_int} <= 3'h1 << (i % 3);
      k = 0;
      while (cpu_hold !== 1'b0 && k < 60) begin
        k = k + 1;
        @(posedge sys_clk);
      end
      // five cycles of sync and state latency, then start-up plus hold
      chk(k, (i < 2) ? 0 : 5 + 6 + `CPS_WAKE_HOLD);
      {wake_wdt, wake_twi_match, wake_ext_int, wake_other_io, wake_adc} <= 5'h00;
    end
    apb(1'b1, `CPS_OFF_SLEEP, 32'h5);
    sleep_now;
    do_reset(1'b1);
    chk(cpu_hold, 1'b0);
    rdc(`CPS_OFF_DIV, 32'h3);
    stop_test;
  end
endmodule // tb_top
